// ==== shared/key_unlock_map.vh ====
// Register map, field positions, signatures and reset values of the key unlock block.
// Included by the design file and the testbench; definitions only.
`ifndef KEY_UNLOCK_MAP_VH
`define KEY_UNLOCK_MAP_VH

// AXI4-Lite byte addresses (index times four)
`define KU_KEY_STATUS_ADDR 8'h1c
`define KU_RESET_REQ_ADDR 8'h20
`define KU_SYS_CTRL_ADDR 8'h28
`define KU_SYS_STATUS_ADDR 8'h2c
`define KU_KEY_DATA_ADDR 8'h30
`define KU_KEY_LOAD_ADDR 8'h34
`define KU_SYNC_EDGE_ADDR 8'h38
`define KU_UROW_ADDR_ADDR 8'h3c

// Key status field positions
`define KU_KS_ERASE 3
`define KU_KS_PROG 4
`define KU_KS_UROW 5
// System control fields
`define KU_SC_KEEP_CLOCK_REQUEST 0
`define KU_SC_COMMIT 1
// System status fields
`define KU_SS_LOCKED 0
`define KU_SS_USER_ROW_PROGRAMMING_FLAG 2
`define KU_SS_PROG 3
`define KU_SS_SLEEP 4
`define KU_SS_RSTSYS 5

// Activation signatures
`define KU_SIG_ERASE 64'h4e564d4572617365
`define KU_SIG_PROG 64'h4e564d50726f6720
`define KU_SIG_UROW 64'h4e564d5573267465
`define KU_RESET_CLEAR 8'h00

// Reset values
`define KU_SYS_CTRL_RESET 8'h01
`define KU_KEEP_CLOCK_REQUEST_RESET 1'b1
`define KU_BOD_ACTIVE 2'h1
`define KU_UROW_BYTES 32

`endif

// ==== hw/key_unlock_access.v ====
// Access layer of a single-wire debug port: activation keys, system reset
// request, lock/programming/sleep status, sync-edge event, clock keep-alive.
// Assumes an AXI4-Lite master stands for the physical layer and that the
// system side supplies lock, sleep and completion levels synchronous to aclk.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "key_unlock_map.vh"

// Function
// - Protected function activates only after the exact key is shifted in.
// - Keys are 64 bits, low byte first, three fixed signatures.
// - Erase key starts full erase, clears lock; cleared by port disable/reset.
// - Programming key works only when unlocked; cleared on completion or reset.
// - User-row key works only while locked; cleared by status write or reset.
// - Active programming key survives a later erase key.
// - Each key has a readable status bit.
// - Reset signature asserts system reset until zero is written.
// - Debugger polls lock bit after erase reset until it reads zero.
// - Locked port has no system bus access, only control space.
// - Brown-out detector forced active with fuse threshold during erase.
// - Programming: key, reset pulse, poll flag, write, reset pulse.
// - User-row mode accepts only first 32 RAM bytes, copied one-to-one.
// - Debugger sets commit bit then polls user-row flag until zero.
// - SRAM reads refused in user-row mode.
// - Unmaskable event for every rising edge in the sync character.
// - Physical layer clock keeps running in sleep while port enabled.
// - No system bus access while sleep stops the CPU clock; here a set clock request bit keeps access open.
// - Sleep flag reads one in idle or deeper sleep.
// - Clock request bit, default one, keeps system clock on in sleep.
module key_unlock_access #(
	parameter ADDR_WIDTH = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire port_enable,
	input wire sync_edge_seen,
	input wire lock_bits_set,
	input wire erase_done,
	input wire program_done,
	input wire user_row_done,
	input wire [1:0] brownout_threshold_fuse,
	input wire system_sleep_idle_or_deeper,
	input wire cpu_clock_stopped,
	input wire sram_read_request,
	input wire [5:0] sram_write_addr,
	input wire sram_write_request,
	output reg system_reset,
	output reg erase_start,
	output reg brownout_force,
	output reg [1:0] brownout_threshold,
	output reg sync_edge_event,
	output reg keep_clock_request,
	output reg phy_clock_run,
	output reg system_bus_allowed,
	output reg sram_read_allowed,
	output reg sram_write_allowed,
	output reg user_row_commit
);

	reg erase_key_active;
	reg memory_program_key;
	reg user_row_key_active;
	reg erase_busy_reg;
	reg [31:0] key_shift_reg;
	reg [31:0] sync_count_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [ADDR_WIDTH-1:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire wr_fire;
	wire user_row_programming_flag;
	wire device_locked_flag;
	wire system_sleeping_flag;
	wire [63:0] key_candidate;
	wire key_load;
	wire [2:0] key_match;
	wire memory_program_flag;
	wire wr_key_data;
	wire wr_key_status;
	wire wr_reset_req;
	wire wr_sys_ctrl;
	reg user_row_finished_reg;
	genvar g;

	// Decode a byte address into a known-register hit
	function is_mapped;
		input [ADDR_WIDTH-1:0] a;
		begin
			case (a)
				`KU_KEY_STATUS_ADDR, `KU_RESET_REQ_ADDR, `KU_SYS_CTRL_ADDR,
				`KU_SYS_STATUS_ADDR, `KU_KEY_DATA_ADDR, `KU_KEY_LOAD_ADDR,
				`KU_SYNC_EDGE_ADDR, `KU_UROW_ADDR_ADDR: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// Signature that opens key slot n: 0 erase, 1 programming, 2 user row
	function [63:0] key_signature;
		input integer n;
		begin
			case (n)
				0: key_signature = `KU_SIG_ERASE;
				1: key_signature = `KU_SIG_PROG;
				default: key_signature = `KU_SIG_UROW;
			endcase
		end
	endfunction

	// Write address and data are captured independently, in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	// One read in flight: a new address waits until the data is taken
	assign s_axi_arready = !s_axi_rvalid;

	// Status levels come straight from the system side
	assign device_locked_flag = lock_bits_set;
	assign system_sleeping_flag = system_sleep_idle_or_deeper;
	// user-row mode only while locked; drops once the row is copied
	assign user_row_programming_flag = user_row_key_active && lock_bits_set && !system_reset &&
		!user_row_finished_reg;
	// programming enabled only unlocked and out of system reset
	assign memory_program_flag = memory_program_key && !lock_bits_set && !system_reset;
	// low word first, upper word triggers comparison
	assign key_candidate = {w_data_reg, key_shift_reg};
	assign key_load = wr_fire && aw_addr_reg == `KU_KEY_LOAD_ADDR;

	// one full 64-bit comparator per key; a partial match sets nothing
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_match
			assign key_match[g] = key_load && key_candidate == key_signature(g);
		end
	endgenerate

	// Write strobes, each decoded once; byte 0 carries every control field
	assign wr_key_data = wr_fire && aw_addr_reg == `KU_KEY_DATA_ADDR && w_strb_reg == 4'hf;
	assign wr_key_status = wr_fire && aw_addr_reg == `KU_KEY_STATUS_ADDR && w_strb_reg[0];
	assign wr_reset_req = wr_fire && aw_addr_reg == `KU_RESET_REQ_ADDR && w_strb_reg[0];
	assign wr_sys_ctrl = wr_fire && aw_addr_reg == `KU_SYS_CTRL_ADDR && w_strb_reg[0];

	// Write channel holding registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= {ADDR_WIDTH{1'b0}};
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr_reg) ? 2'h0 : 2'h2; // SLVERR unmapped
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes, key matching and key lifetime
	always @(posedge aclk) begin
		if (!aresetn) begin
			key_shift_reg <= 32'h0;
			erase_key_active <= 1'b0;
			memory_program_key <= 1'b0;
			user_row_key_active <= 1'b0;
			system_reset <= 1'b0;
			keep_clock_request <= `KU_KEEP_CLOCK_REQUEST_RESET;
			user_row_commit <= 1'b0;
			erase_busy_reg <= 1'b0;
			user_row_finished_reg <= 1'b0;
		end else begin
			// Commit is a one-cycle strobe unless written below
			user_row_commit <= 1'b0;
			if (wr_key_data)
				key_shift_reg <= w_data_reg;
			// erase key lost when port disabled
			if (!port_enable)
				erase_key_active <= 1'b0;
			else if (key_match[0])
				erase_key_active <= 1'b1;
			// erase key leaves programming key alone
			// mismatch changes nothing; a new key beats a completion
			if (key_match[1])
				memory_program_key <= 1'b1;
			else if (program_done)
				memory_program_key <= 1'b0;
			// cleared by status write, new key wins
			if (key_match[2])
				user_row_key_active <= 1'b1;
			else if (wr_key_status && w_data_reg[`KU_KS_UROW])
				user_row_key_active <= 1'b0;
			// flag drops once the row copy reports done, until the key goes
			if (user_row_done && user_row_key_active)
				user_row_finished_reg <= 1'b1;
			else if (!user_row_key_active)
				user_row_finished_reg <= 1'b0;
			if (wr_reset_req)
				system_reset <= w_data_reg[7:0] != `KU_RESET_CLEAR;
			if (wr_sys_ctrl) begin
				keep_clock_request <= w_data_reg[`KU_SC_KEEP_CLOCK_REQUEST];
				user_row_commit <= w_data_reg[`KU_SC_COMMIT] && user_row_programming_flag;
			end
			// Every reset pulse with the erase key held starts another erase
			// erase runs from reset pulse until done
			if (erase_done)
				erase_busy_reg <= 1'b0;
			else if (erase_key_active && system_reset)
				erase_busy_reg <= 1'b1;
		end
	end

	// Sync character edge event and counter
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync_edge_event <= 1'b0;
			sync_count_reg <= 32'h0;
		end else begin
			sync_edge_event <= sync_edge_seen;
			// Count wraps; the debugger only compares successive reads
			if (sync_edge_seen)
				sync_count_reg <= sync_count_reg + 32'h1;
		end
	end

	// Erase side effects and link clock, registered for clean levels
	always @(posedge aclk) begin
		if (!aresetn) begin
			erase_start <= 1'b0;
			brownout_force <= 1'b0;
			brownout_threshold <= 2'h0;
			phy_clock_run <= 1'b0;
		end else begin
			// erase held for the whole busy window
			erase_start <= erase_busy_reg;
			brownout_force <= erase_busy_reg;
			brownout_threshold <= brownout_threshold_fuse;
			phy_clock_run <= port_enable;
		end
	end

	// Access gates; at the next edge a lock closes bus and SRAM read, a reset closes bus and SRAM write
	always @(posedge aclk) begin
		if (!aresetn) begin
			system_bus_allowed <= 1'b0;
			sram_read_allowed <= 1'b0;
			sram_write_allowed <= 1'b0;
		end else begin
			system_bus_allowed <= !lock_bits_set && !system_reset &&
				(!cpu_clock_stopped || keep_clock_request);
			// no SRAM read in user-row mode
			sram_read_allowed <= sram_read_request && !user_row_programming_flag &&
				!lock_bits_set;
			sram_write_allowed <= sram_write_request && user_row_programming_flag &&
				sram_write_addr < `KU_UROW_BYTES;
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			// Address decoded at acceptance, so the data cannot shift later
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			s_axi_rdata <= 32'h0;
			case (s_axi_araddr)
				`KU_KEY_STATUS_ADDR: begin
					s_axi_rdata[`KU_KS_ERASE] <= erase_key_active;
					s_axi_rdata[`KU_KS_PROG] <= memory_program_key;
					s_axi_rdata[`KU_KS_UROW] <= user_row_key_active;
				end
				`KU_RESET_REQ_ADDR: s_axi_rdata[0] <= system_reset;
				`KU_SYS_CTRL_ADDR: s_axi_rdata[`KU_SC_KEEP_CLOCK_REQUEST] <= keep_clock_request;
				`KU_SYS_STATUS_ADDR: begin
					s_axi_rdata[`KU_SS_LOCKED] <= device_locked_flag;
					s_axi_rdata[`KU_SS_USER_ROW_PROGRAMMING_FLAG] <= user_row_programming_flag;
					s_axi_rdata[`KU_SS_PROG] <= memory_program_flag;
					s_axi_rdata[`KU_SS_SLEEP] <= system_sleeping_flag;
					s_axi_rdata[`KU_SS_RSTSYS] <= system_reset;
				end
				`KU_KEY_DATA_ADDR: s_axi_rdata <= key_shift_reg;
				`KU_SYNC_EDGE_ADDR: s_axi_rdata <= sync_count_reg;
				// Reserved and unmapped offsets read as zero
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== tb/key_unlock_access_chk.sv ====
// Port checker for the key unlock block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module key_unlock_access_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire sync_edge_seen,
	input wire sync_edge_event,
	input wire port_enable,
	input wire phy_clock_run,
	input wire erase_start,
	input wire brownout_force,
	input wire system_reset,
	input wire lock_bits_set,
	input wire system_bus_allowed,
	input wire [1:0] brownout_threshold,
	input wire [1:0] brownout_threshold_fuse,
	input wire [5:0] sram_write_addr,
	input wire sram_write_allowed,
	input wire user_row_commit
);
	// One clock domain, so one default clocking and disable
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_sync_event: assert property (sync_edge_seen |=> sync_edge_event)
		else $error("sync edge event missing");
	a_sync_quiet: assert property (!sync_edge_seen |=> !sync_edge_event)
		else $error("sync edge event without edge");
	a_phy_run: assert property (port_enable |=> phy_clock_run)
		else $error("link clock stopped while enabled");
	a_bod_force: assert property (erase_start |-> brownout_force &&
		brownout_threshold == $past(brownout_threshold_fuse))
		else $error("brownout not forced during erase");
	a_erase_cause: assert property ($rose(erase_start) |-> $past(system_reset))
		else $error("erase started without reset");
	a_locked_bus: assert property (lock_bits_set |=> !system_bus_allowed)
		else $error("bus open while locked");
	a_commit_pulse: assert property (user_row_commit |=> !user_row_commit)
		else $error("commit longer than one cycle");
	a_urow_range: assert property (sram_write_addr >= 6'h20 |=> !sram_write_allowed)
		else $error("user row write beyond 32 bytes");
endmodule
bind key_unlock_access key_unlock_access_chk u_chk (.*);
`default_nettype wire

// ==== tb/system_side_model.sv ====
// System side model: holds the lock bits and runs the erase.
// Assumes erase_start stays high until erase_done is seen.
`timescale 1ns/1ps
`default_nettype none
module system_side_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic erase_start,
	input wire logic user_row_commit,
	output logic lock_bits_set,
	output logic erase_done,
	output logic user_row_done
);
	logic [2:0] cnt_reg;
	logic commit_seen_reg;
	// row copy reports done two cycles after the commit strobe
	always @(posedge aclk) begin
		if (!aresetn) begin
			commit_seen_reg <= 1'b0;
			user_row_done <= 1'b0;
		end else begin
			commit_seen_reg <= user_row_commit;
			user_row_done <= commit_seen_reg;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 3'h0;
			lock_bits_set <= 1'b1;
			erase_done <= 1'b0;
		end else begin
			erase_done <= 1'b0;
			if (erase_start && !erase_done) begin
				cnt_reg <= cnt_reg + 3'h1;
				if (cnt_reg == 3'h3) begin
					erase_done <= 1'b1;
					lock_bits_set <= 1'b0;
					cnt_reg <= 3'h0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/key_unlock_access_tb.sv ====
// Bench for the key unlock block: register accesses over AXI4-Lite.
// Assumes the system side model answers the erase.
`timescale 1ns/1ps
`default_nettype none
`include "key_unlock_map.vh"
module key_unlock_access_tb;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, q;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, port_enable = 0;
	logic sync_edge_seen = 0, program_done = 0;
	logic system_sleep_idle_or_deeper = 0, cpu_clock_stopped = 0;
	logic sram_read_request = 0, sram_write_request = 0;
	logic [5:0] sram_write_addr = 0;
	logic [1:0] brownout_threshold_fuse = 2'h2, r;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire lock_bits_set, erase_done, system_reset, erase_start, brownout_force;
	wire sync_edge_event, keep_clock_request, phy_clock_run, system_bus_allowed;
	wire sram_read_allowed, sram_write_allowed, user_row_commit, user_row_done;
	wire [1:0] s_axi_bresp, s_axi_rresp, brownout_threshold;
	wire [31:0] s_axi_rdata;
	int n_mismatch = 0;
	int n_tests = 0;

	key_unlock_access u_dut (.*);
	system_side_model u_sys (.*);

	// Free-running 200 MHz clock
	always #2.5 aclk = ~aclk;

	task end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input [31:0] s, input [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, s, e);
		end
	endtask

	// A used-up wait bound ends the run
	task tmo(input int i);
		if (i >= 99) begin
			n_mismatch++;
			end_sim;
		end
	endtask

	// Ready is sampled mid-cycle, the source released at the next edge
	task wr(input [7:0] a, input [31:0] d);
		int i;
		logic pa, pw, ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		pa = 1;
		pw = 1;
		for (i = 0; i < 50 && (pa || pw); i++) begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		for (ta = 0; i < 99 && !ta; i++) begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end
		s_axi_bready <= 0;
		tmo(i);
	endtask

	task rd(input [7:0] a);
		int i;
		logic t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (i = 0, t = 0; i < 50 && !t; i++) begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 0;
		for (t = 0; i < 99 && !t; i++) begin
			@(negedge aclk);
			t = s_axi_rvalid;
			q = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end
		s_axi_rready <= 0;
		tmo(i);
	endtask

	// Low word first, compare happens on the high word
	task key(input [63:0] k);
		wr(`KU_KEY_DATA_ADDR, k[31:0]);
		wr(`KU_KEY_LOAD_ADDR, k[63:32]);
	endtask

	// Main sequence
	initial begin
		int j;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		port_enable <= 1;
		rd(`KU_SYS_CTRL_ADDR);
		chk(q, 32'h1);
		key(`KU_SIG_ERASE ^ 64'h1);
		rd(`KU_KEY_STATUS_ADDR);
		chk(q, 32'h0);
		key(`KU_SIG_UROW);
		rd(`KU_KEY_STATUS_ADDR);
		chk(q, 32'h20);
		wr(`KU_RESET_REQ_ADDR, 32'h1);
		wr(`KU_RESET_REQ_ADDR, 32'h0);
		rd(`KU_SYS_STATUS_ADDR);
		chk(q[`KU_SS_USER_ROW_PROGRAMMING_FLAG], 1);
		sram_read_request <= 1;
		sram_write_request <= 1;
		sram_write_addr <= 6'h1f;
		@(posedge aclk);
		#1 chk(sram_write_allowed, 1);
		chk(sram_read_allowed, 0);
		sram_write_addr <= 6'h20;
		@(posedge aclk);
		#1 chk(sram_write_allowed, 0);
		sram_write_request <= 0;
		sram_read_request <= 0;
		wr(`KU_SYS_CTRL_ADDR, 32'h3);
		for (j = 0; j < 20; j++) begin
			rd(`KU_SYS_STATUS_ADDR);
			if (q[`KU_SS_USER_ROW_PROGRAMMING_FLAG] === 1'b0) break;
		end
		chk(q[`KU_SS_USER_ROW_PROGRAMMING_FLAG], 0);
		wr(`KU_KEY_STATUS_ADDR, 32'h20);
		wr(`KU_RESET_REQ_ADDR, 32'h1);
		wr(`KU_RESET_REQ_ADDR, 32'h0);
		rd(`KU_KEY_STATUS_ADDR);
		chk(q, 32'h0);
		key(`KU_SIG_PROG);
		key(`KU_SIG_ERASE);
		rd(`KU_KEY_STATUS_ADDR);
		chk(q, 32'h18);
		wr(`KU_RESET_REQ_ADDR, 32'h1);
		#1 chk(system_reset, 1);
		wr(`KU_RESET_REQ_ADDR, 32'h0);
		#1 chk(system_reset, 0);
		for (j = 0; j < 20; j++) begin
			rd(`KU_SYS_STATUS_ADDR);
			if (q[`KU_SS_LOCKED] === 1'b0) break;
		end
		chk(q[`KU_SS_LOCKED], 0);
		chk(q[`KU_SS_PROG], 1);
		#1 chk(system_bus_allowed, 1);
		chk(brownout_threshold, 2'h2);
		program_done <= 1;
		@(posedge aclk);
		program_done <= 0;
		rd(`KU_KEY_STATUS_ADDR);
		chk(q, 32'h8);
		port_enable <= 0;
		repeat (2) @(posedge aclk);
		port_enable <= 1;
		rd(`KU_KEY_STATUS_ADDR);
		chk(q, 32'h0);
		repeat (3) begin
			sync_edge_seen <= 1;
			@(posedge aclk);
			sync_edge_seen <= 0;
			@(posedge aclk);
		end
		rd(`KU_SYNC_EDGE_ADDR);
		chk(q, 32'h3);
		system_sleep_idle_or_deeper <= 1;
		cpu_clock_stopped <= 1;
		sram_read_request <= 1;
		wr(`KU_SYS_CTRL_ADDR, 32'h0);
		rd(`KU_SYS_STATUS_ADDR);
		chk(q[`KU_SS_SLEEP], 1);
		#1 chk(system_bus_allowed, 0);
		wr(`KU_SYS_CTRL_ADDR, 32'h1);
		repeat (2) @(posedge aclk);
		#1 chk({keep_clock_request, system_bus_allowed}, 3);
		chk(sram_read_allowed, 1);
		rd(8'h40);
		chk({r, q}, {2'h2, 32'h0});
		wr(8'h44, 32'h0);
		chk(r, 2'h2);
		end_sim;
	end
endmodule
`default_nettype wire
